// >>> hdl/sq_bit_scan.sv
`default_nettype none
module sq_bit_scan #(
    parameter int W = 16,
    parameter int PW = 4
) (
    input wire logic [W-1:0] word,
    output logic [PW-1:0] pos,
    output logic found
);
    logic [W-1:0] hit;
    logic [W-1:0][PW-1:0] code;
    // Lowest set bit wins
    genvar i;
    for (i = 0; i < W; i++) begin : g_bit
        if (i == 0) begin : g_lsb
            assign hit[i] = word[i];
        end else begin : g_up
            assign hit[i] = word[i] & ~(|word[i-1:0]);
        end
        assign code[i] = hit[i] ? PW'(i) : '0;
    end
    always_comb begin
        pos = '0;
        for (int k = 0; k < W; k++) begin
            pos = pos | code[k];
        end
    end
    assign found = |word;
endmodule
`default_nettype wire

// >>> hdl/sq_pkg.sv
`default_nettype none
package sq_pkg;
    typedef enum logic [4:0] {
        SQ_NOP = 5'h00, SQ_FAST_EXIT = 5'h01, SQ_INT_EXIT = 5'h02, SQ_FRAME_OPEN = 5'h03,
        SQ_FRAME_CLOSE = 5'h04, SQ_SUB_WORD = 5'h05, SQ_SUB_LONG = 5'h06,
        SQ_LIST_PUSH = 5'h07, SQ_LIST_POP = 5'h08, SQ_BANK_TO_ACC = 5'h09,
        SQ_GUARD_UPPER = 5'h0A, SQ_GUARD_LOWER = 5'h0B, SQ_GUARD_ON = 5'h0C,
        SQ_GUARD_OFF = 5'h0D, SQ_FLAG_HOLD = 5'h0E, SQ_BANK_PREFIX = 5'h0F,
        SQ_SCAN_X1 = 5'h10, SQ_SCAN_X2 = 5'h11, SQ_SCAN_X4 = 5'h12, SQ_BIT_CLR_BR = 5'h13,
        SQ_BIT_SET_BR = 5'h14, SQ_TEST_SET_BR = 5'h15, SQ_WAIT_HIGH = 5'h16,
        SQ_WAIT_LOW = 5'h17, SQ_STR_COPY = 5'h18, SQ_STR_SEARCH = 5'h19,
        SQ_STR_FILL = 5'h1A, SQ_BLK_MOVE = 5'h1B
    } sq_op_t;
    typedef enum logic [2:0] {
        SQ_BK_PROG = 3'h0, SQ_BK_EXTRA = 3'h1, SQ_BK_SSTK = 3'h2, SQ_BK_USTK = 3'h3,
        SQ_BK_SPFX = 3'h4, SQ_BK_DATA = 3'h5, SQ_BK_DPAGE = 3'h6, SQ_BK_COMMON = 3'h7
    } sq_bank_t;
    typedef enum logic [1:0] {
        SQ_ST_IDLE = 2'h0, SQ_ST_RUN = 2'h1, SQ_ST_SEARCH = 2'h2, SQ_ST_POLL = 2'h3
    } sq_state_t;
    typedef struct packed {
        sq_op_t op;
        sq_bank_t bank;
        logic wide;
        logic down;
        logic [7:0] imm8;
        logic [15:0] imm16;
        logic [3:0] reg_cnt;
    } sq_cmd_t;
    typedef struct packed {
        logic [15:0] acc_lo;
        logic [15:0] acc_hi;
        logic [15:0] loop_cnt;
        logic [15:0] sp;
        logic [15:0] fp;
        logic [15:0] pc;
        logic [7:0] program_bank_reg;
        logic [23:0] pop_data;
        logic [63:0] bank_vals;
        logic bit_val;
        logic irq_pending;
        logic match;
    } sq_core_t;
    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] program_bank_reg;
        logic [15:0] sp;
        logic [15:0] fp;
        logic [15:0] acc_lo;
        logic [15:0] acc_hi;
        logic [15:0] loop_cnt;
        logic branch;
        logic vector_jump;
        logic bit_write;
        logic flag_hold;
        logic redirect;
        sq_bank_t bank;
        logic [9:0] byte_corr;
        logic [9:0] word_corr;
        logic [9:0] long_corr;
    } sq_res_t;
    typedef struct packed {
        sq_state_t st;
        logic [19:0] rem;
        logic [16:0] elem;
        logic [19:0] spent;
        sq_op_t op;
        sq_res_t res;
        logic [15:0] guard_hi;
        logic [15:0] guard_lo;
        logic guard_en;
    } sq_regs_t;
endpackage
`default_nettype wire

// >>> hdl/sq_regs.svh
`ifndef SQ_REGS_SVH
`define SQ_REGS_SVH
// Cycle figures per instruction
`define SQ_CYC_FAST_EXIT 20'h0_0006
`define SQ_CYC_INT_EXIT 20'h0_000B
`define SQ_CYC_FRAME_OPEN 20'h0_0005
`define SQ_CYC_FRAME_CLOSE 20'h0_0004
`define SQ_CYC_SUB_WORD 20'h0_0004
`define SQ_CYC_SUB_LONG 20'h0_0005
`define SQ_CYC_LIST_BASE 20'h0_0003
`define SQ_CYC_LIST_PER 20'h0_0004
`define SQ_CYC_BANK_FAST 20'h0_0001
`define SQ_CYC_BANK_DATA 20'h0_0002
`define SQ_CYC_BANK_DPAGE 20'h0_0003
`define SQ_CYC_GUARD 20'h0_0002
`define SQ_CYC_PREFIX 20'h0_0001
`define SQ_CYC_SCAN_ZERO 20'h0_0003
`define SQ_CYC_SCAN_HIT 20'h0_0005
`define SQ_CYC_BB_TAKEN 20'h0_0005
`define SQ_CYC_BB_NOT 20'h0_0004
`define SQ_CYC_TAS_MET 20'h0_0007
`define SQ_CYC_TAS_NOT 20'h0_0006
`define SQ_CYC_STR_ZERO 20'h0_0004
`define SQ_CYC_SRCH_ZERO 20'h0_0003
`define SQ_CYC_STR_BASE 20'h0_0002
`define SQ_CYC_STR_PER 20'h0_0006
`define SQ_CYC_FILL_BASE 20'h0_0003
`define SQ_CYC_FILL_PER 20'h0_0005
`define SQ_CYC_BLK_BASE 20'h0_0005
`define SQ_CYC_BLK_PER 20'h0_0005
`define SQ_BLK_ZERO_CNT 17'h0_0100
// Correction counts
`define SQ_COR_FAST_BYTE 10'h003
`define SQ_COR_FAST_WORD 10'h002
`define SQ_COR_RET_WORD 10'h006
`define SQ_COR_ONE 10'h001
`define SQ_SP_STEP 16'h0002
`endif

// >>> hdl/sq_sequencer.sv
// Functional notes
// RULE_01: Interrupt seen during fast exit jumps to vector, skipping stack work.
// RULE_02: Fast exit costs 3 byte plus 2 word corrections, or 6 word.
// RULE_03: Frame open pushes old frame pointer, sets new one, reserves imm8 area.
// RULE_04: Frame close restores old frame pointer from the stack.
// RULE_05: Word exit pops PC; long exit pops PC and program bank.
// RULE_06: List push takes 3+4n cycles, stack pointer drops 2n.
// RULE_07: List pop takes 3+4n cycles, stack pointer rises 2n.
// RULE_08: Bank to accumulator: 1 cycle most banks, 2 data, 3 direct page.
// RULE_09: Load upper and lower stack guard limits; guard on and off.
// RULE_10: Flag hold prefix freezes flags; others redirect the bank.
// RULE_11: Bit scan writes scaled position; base 3 cycles on zero, else 5.
// RULE_12: Bit branch takes 5 cycles when taken, 4 when not.
// RULE_13: Test-and-set branches on one, sets bit locked, 7 or 6 cycles.
// RULE_14: Wait-bit stalls, polling, until the bit reaches its value.
// RULE_15: String copy: 4 cycles on zero count, else 2+6 per element.
// RULE_16: Search: 3 on zero, 2+6m on count-out, 6n+4 on match.
// RULE_17: Fill writes acc low word m times in 5m+3 cycles.
// RULE_18: Block move: 5+5n cycles, immediate zero means 256.
// RULE_19: Each block element costs two corrections at byte or word rate.
// RULE_20: Block move bank choice matches string copy.
// RULE_21: Queue and PC held while iterating instructions run.
`include "sq_regs.svh"
`default_nettype none
module sq_sequencer #(
    parameter int CW = 20
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire sq_pkg::sq_cmd_t cmd,
    input wire sq_pkg::sq_core_t core,
    output logic ready,
    output logic done,
    output logic hold_queue,
    output sq_pkg::sq_res_t res,
    output logic [CW-1:0] cycles,
    output logic guard_en,
    output logic [15:0] guard_hi,
    output logic [15:0] guard_lo
);
    sq_pkg::sq_regs_t q;
    sq_pkg::sq_regs_t d;
    logic [3:0] scan_pos;
    logic scan_found;
    logic run_end;
    logic srch_end;
    logic srch_hit;
    logic poll_hit;
    logic [15:0] elem_step;

    sq_bit_scan #(.W(16), .PW(4)) u_scan (
        .word(core.acc_lo),
        .pos(scan_pos),
        .found(scan_found)
    );

    ////////////////////////////////////////////////////////////////////////////
    assign run_end = (q.st == sq_pkg::SQ_ST_RUN) && (q.rem == '0);
    assign srch_hit = (q.st == sq_pkg::SQ_ST_SEARCH) && (q.rem == '0) && core.match;
    assign srch_end = (q.st == sq_pkg::SQ_ST_SEARCH) && (q.rem == '0) && !core.match
                      && (q.elem == 17'h0_0001);
    assign poll_hit = (q.st == sq_pkg::SQ_ST_POLL)
                      && (core.bit_val == (q.op == sq_pkg::SQ_WAIT_HIGH));
    assign done = run_end || srch_end || poll_hit;
    assign ready = (q.st == sq_pkg::SQ_ST_IDLE);
    assign hold_queue = !ready; // see RULE_21
    assign res = q.res;
    assign cycles = q.spent;
    assign guard_en = q.guard_en;
    assign guard_hi = q.guard_hi;
    assign guard_lo = q.guard_lo;
    assign elem_step = cmd.wide ? `SQ_SP_STEP : 16'h0001;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [CW-1:0] total;
        logic [16:0] n;
        logic [15:0] span;
        total = `SQ_CYC_PREFIX;
        n = '0;
        span = '0;
        d = q;
        case (q.st)
            sq_pkg::SQ_ST_IDLE: begin
                if (start) begin
                    d.op = cmd.op;
                    d.res = q.res;
                    d.res.branch = 1'b0;
                    d.res.vector_jump = 1'b0;
                    d.res.bit_write = 1'b0;
                    d.res.flag_hold = 1'b0;
                    d.res.redirect = 1'b0;
                    d.res.bank = cmd.bank;
                    d.res.byte_corr = '0;
                    d.res.word_corr = '0;
                    d.res.long_corr = '0;
                    d.res.pc = core.pc;
                    d.res.program_bank_reg = core.program_bank_reg;
                    d.res.sp = core.sp;
                    d.res.fp = core.fp;
                    d.res.acc_lo = core.acc_lo;
                    d.res.acc_hi = core.acc_hi;
                    d.res.loop_cnt = core.loop_cnt;
                    d.st = sq_pkg::SQ_ST_RUN;
                    case (cmd.op)
                        sq_pkg::SQ_FAST_EXIT: begin
                            total = `SQ_CYC_FAST_EXIT;
                            if (core.irq_pending) begin
                                d.res.vector_jump = 1'b1; // see RULE_01
                                d.res.byte_corr = `SQ_COR_FAST_BYTE; // see RULE_02
                                d.res.word_corr = `SQ_COR_FAST_WORD;
                            end else begin
                                d.res.word_corr = `SQ_COR_RET_WORD; // see RULE_02
                                d.res.pc = core.pop_data[15:0];
                            end
                        end
                        sq_pkg::SQ_INT_EXIT: begin
                            total = `SQ_CYC_INT_EXIT;
                            d.res.word_corr = `SQ_COR_RET_WORD;
                            d.res.pc = core.pop_data[15:0];
                        end
                        sq_pkg::SQ_FRAME_OPEN: begin
                            total = `SQ_CYC_FRAME_OPEN;
                            d.res.word_corr = `SQ_COR_ONE;
                            // Old frame pointer pushed, frame starts at new top
                            d.res.fp = core.sp - `SQ_SP_STEP; // see RULE_03
                            d.res.sp = core.sp - `SQ_SP_STEP - {8'h00, cmd.imm8};
                        end
                        sq_pkg::SQ_FRAME_CLOSE: begin
                            total = `SQ_CYC_FRAME_CLOSE;
                            d.res.word_corr = `SQ_COR_ONE;
                            d.res.sp = core.fp + `SQ_SP_STEP; // see RULE_04
                            d.res.fp = core.pop_data[15:0];
                        end
                        sq_pkg::SQ_SUB_WORD: begin
                            total = `SQ_CYC_SUB_WORD;
                            d.res.word_corr = `SQ_COR_ONE;
                            d.res.pc = core.pop_data[15:0]; // see RULE_05
                            d.res.sp = core.sp + `SQ_SP_STEP;
                        end
                        sq_pkg::SQ_SUB_LONG: begin
                            total = `SQ_CYC_SUB_LONG;
                            d.res.long_corr = `SQ_COR_ONE;
                            d.res.pc = core.pop_data[15:0]; // see RULE_05
                            d.res.program_bank_reg = core.pop_data[23:16];
                            d.res.sp = core.sp + `SQ_SP_STEP + `SQ_SP_STEP;
                        end
                        sq_pkg::SQ_LIST_PUSH, sq_pkg::SQ_LIST_POP: begin
                            total = `SQ_CYC_LIST_BASE + `SQ_CYC_LIST_PER * CW'(cmd.reg_cnt);
                            d.res.word_corr = 10'(cmd.reg_cnt);
                            span = 16'(cmd.reg_cnt) * `SQ_SP_STEP;
                            if (cmd.op == sq_pkg::SQ_LIST_PUSH) begin
                                d.res.sp = core.sp - span; // see RULE_06
                            end else begin
                                d.res.sp = core.sp + span; // see RULE_07
                            end
                        end
                        sq_pkg::SQ_BANK_TO_ACC: begin
                            if (cmd.bank == sq_pkg::SQ_BK_DATA) begin
                                total = `SQ_CYC_BANK_DATA; // see RULE_08
                            end else if (cmd.bank == sq_pkg::SQ_BK_DPAGE) begin
                                total = `SQ_CYC_BANK_DPAGE; // see RULE_08
                            end else begin
                                total = `SQ_CYC_BANK_FAST; // see RULE_08
                            end
                            d.res.acc_lo = {8'h00, core.bank_vals[{cmd.bank, 3'h0} +: 8]};
                        end
                        sq_pkg::SQ_GUARD_UPPER: begin
                            total = `SQ_CYC_GUARD;
                            d.guard_hi = cmd.imm16; // see RULE_09
                        end
                        sq_pkg::SQ_GUARD_LOWER: begin
                            total = `SQ_CYC_GUARD;
                            d.guard_lo = cmd.imm16; // see RULE_09
                        end
                        sq_pkg::SQ_GUARD_ON, sq_pkg::SQ_GUARD_OFF: begin
                            total = `SQ_CYC_GUARD;
                            d.guard_en = (cmd.op == sq_pkg::SQ_GUARD_ON); // see RULE_09
                        end
                        sq_pkg::SQ_FLAG_HOLD: begin
                            d.res.flag_hold = 1'b1; // see RULE_10
                        end
                        sq_pkg::SQ_BANK_PREFIX: begin
                            d.res.redirect = 1'b1; // see RULE_10
                        end
                        sq_pkg::SQ_SCAN_X1, sq_pkg::SQ_SCAN_X2, sq_pkg::SQ_SCAN_X4: begin
                            // Wider scales cost one or two more cycles
                            total = (scan_found ? `SQ_CYC_SCAN_HIT : `SQ_CYC_SCAN_ZERO)
                                    + CW'(cmd.op - sq_pkg::SQ_SCAN_X1); // see RULE_11
                            d.res.acc_lo = {8'h00, 8'({4'h0, scan_pos}
                                           << (cmd.op - sq_pkg::SQ_SCAN_X1))};
                        end
                        sq_pkg::SQ_BIT_CLR_BR, sq_pkg::SQ_BIT_SET_BR: begin
                            d.res.branch = core.bit_val == (cmd.op == sq_pkg::SQ_BIT_SET_BR);
                            total = d.res.branch ? `SQ_CYC_BB_TAKEN : `SQ_CYC_BB_NOT; // see RULE_12
                        end
                        sq_pkg::SQ_TEST_SET_BR: begin
                            d.res.branch = core.bit_val;
                            d.res.bit_write = 1'b1; // see RULE_13
                            d.res.byte_corr = `SQ_COR_FAST_WORD;
                            total = core.bit_val ? `SQ_CYC_TAS_MET : `SQ_CYC_TAS_NOT; // see RULE_13
                        end
                        sq_pkg::SQ_WAIT_HIGH, sq_pkg::SQ_WAIT_LOW: begin
                            d.st = sq_pkg::SQ_ST_POLL; // see RULE_14
                        end
                        sq_pkg::SQ_STR_COPY, sq_pkg::SQ_STR_FILL: begin
                            n = {1'b0, core.loop_cnt};
                            span = core.loop_cnt * elem_step;
                            if (cmd.op == sq_pkg::SQ_STR_FILL) begin
                                total = `SQ_CYC_FILL_BASE + `SQ_CYC_FILL_PER * CW'(n); // see RULE_17
                            end else if (n == '0) begin
                                total = `SQ_CYC_STR_ZERO; // see RULE_15
                            end else begin
                                total = `SQ_CYC_STR_BASE + `SQ_CYC_STR_PER * CW'(n); // see RULE_15
                                d.res.acc_lo = cmd.down ? core.acc_lo - span
                                                        : core.acc_lo + span;
                            end
                            d.res.acc_hi = cmd.down ? core.acc_hi - span : core.acc_hi + span;
                            d.res.loop_cnt = '0;
                            d.res.redirect = 1'b1;
                            if (cmd.wide) begin
                                d.res.word_corr = 10'(core.loop_cnt);
                            end else begin
                                d.res.byte_corr = 10'(core.loop_cnt);
                            end
                        end
                        sq_pkg::SQ_STR_SEARCH: begin
                            if (core.loop_cnt == '0) begin
                                total = `SQ_CYC_SRCH_ZERO; // see RULE_16
                            end else begin
                                d.st = sq_pkg::SQ_ST_SEARCH;
                                d.elem = {1'b0, core.loop_cnt};
                                total = `SQ_CYC_STR_BASE + `SQ_CYC_STR_PER;
                            end
                        end
                        sq_pkg::SQ_BLK_MOVE: begin
                            n = (cmd.imm8 == 8'h00) ? `SQ_BLK_ZERO_CNT : {9'h000, cmd.imm8};
                            total = `SQ_CYC_BLK_BASE + `SQ_CYC_BLK_PER * CW'(n); // see RULE_18
                            d.res.redirect = 1'b1; // see RULE_20
                            if (cmd.wide) begin
                                d.res.word_corr = 10'(n) + 10'(n); // see RULE_19
                            end else begin
                                d.res.byte_corr = 10'(n) + 10'(n); // see RULE_19
                            end
                        end
                        default: begin
                            total = `SQ_CYC_PREFIX;
                        end
                    endcase
                    d.rem = total - CW'(1);
                    d.spent = CW'(1);
                end
            end
            sq_pkg::SQ_ST_RUN: begin
                d.spent = q.spent + CW'(1);
                if (q.rem == '0) begin
                    d.st = sq_pkg::SQ_ST_IDLE;
                    d.spent = q.spent;
                end else begin
                    d.rem = q.rem - CW'(1);
                end
            end
            sq_pkg::SQ_ST_SEARCH: begin
                d.spent = q.spent + CW'(1);
                if (q.rem != '0) begin
                    d.rem = q.rem - CW'(1);
                end else begin
                    d.res.acc_hi = q.res.acc_hi + elem_step;
                    if (core.match) begin
                        d.st = sq_pkg::SQ_ST_RUN; // see RULE_16
                        d.rem = CW'(1);
                    end else if (q.elem == 17'h0_0001) begin
                        d.st = sq_pkg::SQ_ST_IDLE; // see RULE_16
                        d.spent = q.spent;
                    end else begin
                        d.elem = q.elem - 17'h0_0001;
                        d.rem = `SQ_CYC_STR_PER - CW'(1);
                    end
                end
            end
            default: begin
                d.spent = q.spent + CW'(1);
                if (poll_hit) begin
                    d.st = sq_pkg::SQ_ST_IDLE; // see RULE_14
                    d.spent = q.spent;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_push_start;
        start && ready && cmd.op == sq_pkg::SQ_LIST_PUSH;
    endsequence
    sequence s_idle_after;
        ready;
    endsequence

    // Long block moves outrun a plain delay, so count their busy cycles
    logic blk_zero_q;
    logic [10:0] blk_cnt_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            blk_zero_q <= 1'b0;
            blk_cnt_q <= '0;
        end else if (start && ready) begin
            blk_zero_q <= (cmd.op == sq_pkg::SQ_BLK_MOVE) && (cmd.imm8 == 8'h00);
            blk_cnt_q <= '0;
        end else if (!ready) begin
            blk_cnt_q <= blk_cnt_q + 11'h001;
        end
    end

    fast_exit_vec_a: assert property (@(posedge clk) disable iff (srst) // see RULE_01
        start && ready && cmd.op == sq_pkg::SQ_FAST_EXIT && core.irq_pending
        |=> res.vector_jump && res.byte_corr == 10'h003 && res.word_corr == 10'h002 ##5 done)
        else $error("fast exit with pending irq wrong");
    fast_exit_ret_a: assert property (@(posedge clk) disable iff (srst) // see RULE_02
        start && ready && cmd.op == sq_pkg::SQ_FAST_EXIT && !core.irq_pending
        |=> !res.vector_jump && res.word_corr == 10'h006)
        else $error("fast exit return corrections wrong");
    list_push_a: assert property (@(posedge clk) disable iff (srst) // see RULE_06
        s_push_start ##0 (cmd.reg_cnt == 4'h3) |=> (res.sp == $past(core.sp) - 16'h0006)
        ##14 done ##1 s_idle_after)
        else $error("push list timing or stack wrong");
    bank_dpage_a: assert property (@(posedge clk) disable iff (srst) // see RULE_08
        start && ready && cmd.op == sq_pkg::SQ_BANK_TO_ACC && cmd.bank == sq_pkg::SQ_BK_DPAGE
        |=> !done ##1 !done ##1 done)
        else $error("direct page move not three cycles");
    scan_zero_a: assert property (@(posedge clk) disable iff (srst) // see RULE_11
        start && ready && cmd.op == sq_pkg::SQ_SCAN_X1 && core.acc_lo == 16'h0000
        |=> !done [*2] ##1 done)
        else $error("scan of zero not three cycles");
    bit_branch_a: assert property (@(posedge clk) disable iff (srst) // see RULE_12
        start && ready && cmd.op == sq_pkg::SQ_BIT_SET_BR && core.bit_val
        |=> res.branch ##4 done)
        else $error("taken bit branch not five cycles");
    poll_stall_a: assert property (@(posedge clk) disable iff (srst) // see RULE_14
        q.st == sq_pkg::SQ_ST_POLL && !core.bit_val && q.op == sq_pkg::SQ_WAIT_HIGH
        |-> !done && hold_queue)
        else $error("wait bit released early");
    blk_zero_a: assert property (@(posedge clk) disable iff (srst) // see RULE_18
        start && ready && cmd.op == sq_pkg::SQ_BLK_MOVE && cmd.imm8 == 8'h00
        |=> (res.byte_corr + res.word_corr) == 10'h200)
        else $error("block move of 256 wrong");
    blk_time_a: assert property (@(posedge clk) disable iff (srst) // see RULE_18
        blk_zero_q && done |-> blk_cnt_q == 11'h504)
        else $error("block move of 256 not 1285 cycles");
    hold_busy_a: assert property (@(posedge clk) disable iff (srst) // see RULE_21
        q.st == sq_pkg::SQ_ST_SEARCH |-> hold_queue && !ready)
        else $error("queue not held during search");
    fill_time_a: assert property (@(posedge clk) disable iff (srst) // see RULE_17
        start && ready && cmd.op == sq_pkg::SQ_STR_FILL && core.loop_cnt == 16'h0001
        |=> !done [*7] ##1 done)
        else $error("fill of one not eight cycles");
endmodule
`default_nettype wire

// >>> testbench/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, srst = 1, start = 0, ready, done, hold_queue, guard_en;
    sq_pkg::sq_cmd_t c = '0;
    sq_pkg::sq_core_t k = '0;
    sq_pkg::sq_res_t res;
    logic [19:0] cycles;
    logic [15:0] guard_hi, guard_lo;
    int error_cnt = 0, num_checks = 0, ticks = 0;
    always #10 clk = ~clk;
    sq_sequencer i_sq_sequencer (.clk(clk), .srst(srst), .start(start), .cmd(c), .core(k),
        .ready(ready), .done(done), .hold_queue(hold_queue), .res(res), .cycles(cycles),
        .guard_en(guard_en), .guard_hi(guard_hi), .guard_lo(guard_lo));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Longest test is the 256-element block move
    always @(posedge clk) begin
        ticks++;
        if (ticks == 5000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Returns one cycle after done, so the next take is never refused
    task automatic go(input sq_pkg::sq_op_t op);
        int i;
        c.op = op;
        start = 1;
        @(posedge clk);
        #1 start = 0;
        chk(hold_queue, 1);
        for (i = 0; i < 2000 && done !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_bits();
        k.bit_val = 1;
        go(sq_pkg::SQ_BIT_SET_BR); chk(cycles, 5); chk(res.branch, 1);
        go(sq_pkg::SQ_BIT_CLR_BR); chk(cycles, 4); chk(res.branch, 0);
        go(sq_pkg::SQ_TEST_SET_BR); chk(cycles, 7); chk(res.bit_write, 1);
        k.bit_val = 0;
        go(sq_pkg::SQ_TEST_SET_BR); chk(cycles, 6); chk(res.branch, 0);
        fork
            go(sq_pkg::SQ_WAIT_HIGH);
            begin repeat (4) @(posedge clk); #1 k.bit_val = 1; end
        join
        chk(cycles, 4);
        $display("t_bits finished");
    endtask
    task automatic t_scan();
        sq_pkg::sq_op_t ops[3] = '{sq_pkg::SQ_SCAN_X1, sq_pkg::SQ_SCAN_X2, sq_pkg::SQ_SCAN_X4};
        for (int s = 0; s < 3; s++) begin
            k.acc_lo = 16'h0000; go(ops[s]); chk(cycles, 3 + s);
            k.acc_lo = 16'h0028; go(ops[s]); chk(cycles, 5 + s);
            chk(res.acc_lo[7:0], 3 << s);
        end
        $display("t_scan finished");
    endtask
    task automatic t_stack();
        sq_pkg::sq_bank_t bk[3] = '{sq_pkg::SQ_BK_SPFX, sq_pkg::SQ_BK_DATA, sq_pkg::SQ_BK_DPAGE};
        k.sp = 16'h0100; c.reg_cnt = 3;
        go(sq_pkg::SQ_LIST_PUSH); chk(cycles, 15); chk(res.sp, 16'h00fa);
        go(sq_pkg::SQ_LIST_POP); chk(cycles, 15); chk(res.sp, 16'h0106);
        for (int b = 0; b < 3; b++) begin
            c.bank = bk[b]; go(sq_pkg::SQ_BANK_TO_ACC); chk(cycles, b + 1);
        end
        c.imm16 = 16'h1234; go(sq_pkg::SQ_GUARD_UPPER); chk(guard_hi, 16'h1234);
        c.imm16 = 16'h0042; go(sq_pkg::SQ_GUARD_LOWER); chk(guard_lo, 16'h0042);
        go(sq_pkg::SQ_GUARD_ON); chk(guard_en, 1);
        go(sq_pkg::SQ_GUARD_OFF); chk(guard_en, 0);
        $display("t_stack finished");
    endtask
    task automatic t_move();
        k.loop_cnt = 0; go(sq_pkg::SQ_STR_COPY); chk(cycles, 4);
        go(sq_pkg::SQ_STR_SEARCH); chk(cycles, 3);
        k.loop_cnt = 3; go(sq_pkg::SQ_STR_COPY); chk(cycles, 20);
        go(sq_pkg::SQ_STR_SEARCH); chk(cycles, 20);
        go(sq_pkg::SQ_STR_FILL); chk(cycles, 18);
        k.match = 1; go(sq_pkg::SQ_STR_SEARCH); chk(cycles, 10); k.match = 0;
        k.loop_cnt = 1; go(sq_pkg::SQ_STR_FILL); chk(cycles, 8);
        c.imm8 = 0; c.wide = 1; go(sq_pkg::SQ_BLK_MOVE); chk(cycles, 1285);
        chk(res.word_corr, 512);
        chk(res.redirect, 1);
        c.imm8 = 2; c.wide = 0; go(sq_pkg::SQ_BLK_MOVE); chk(res.byte_corr, 4);
        $display("t_move finished");
    endtask
    task automatic t_exit();
        k.irq_pending = 1; go(sq_pkg::SQ_FAST_EXIT); chk(res.vector_jump, 1);
        chk(res.byte_corr, 3); chk(res.word_corr, 2); chk(cycles, 6);
        k.irq_pending = 0; go(sq_pkg::SQ_FAST_EXIT); chk(res.word_corr, 6);
        c.imm8 = 8'h10; k.sp = 16'h0100; go(sq_pkg::SQ_FRAME_OPEN); chk(res.fp, 16'h00fe);
        chk(res.sp, 16'h00ee); chk(cycles, 5);
        k.fp = 16'h0080; k.pop_data = 24'h12_3456; go(sq_pkg::SQ_FRAME_CLOSE);
        chk(res.sp, 16'h0082); chk(res.fp, 16'h3456);
        go(sq_pkg::SQ_SUB_WORD); chk(res.pc, 16'h3456); chk(res.sp, 16'h0102);
        go(sq_pkg::SQ_SUB_LONG); chk(res.program_bank_reg, 8'h12); chk(res.sp, 16'h0104);
        go(sq_pkg::SQ_FLAG_HOLD); chk(res.flag_hold, 1);
        c.bank = sq_pkg::SQ_BK_DATA; go(sq_pkg::SQ_BANK_PREFIX); chk(res.redirect, 1);
        chk(res.bank, 5); chk(res.flag_hold, 0);
        $display("t_exit finished");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1 srst = 0;
        t_bits(); t_scan(); t_stack(); t_move(); t_exit();
        tally_and_finish();
    end
endmodule
`default_nettype wire
